// *** logic/pscr_loader.sv ***
// PLL scan chain cache and loader with an AXI4-Lite register port
//
// Summary of operation
// - Apply request sampled on rising edge starts shifting cache into PLL.
// - Busy rises on apply and stays high through whole reconfiguration.
// - Cache is never altered by an apply; later applies reuse all fields.
// - Reset puts the state machine into idle; needed before first use.
// - When enabled, chain-done input holds busy until bits have shifted.
// - Counter select: 0 n, 1 m, 01xx core, 100x local, 11xx external.
// - Param select: 000/001 nine bits, 010 delay, 100 bypass, 101 odd.
// - Read returns selected field right-aligned, valid once busy falls.
// - Busy on read, write or apply; requests ignored while busy.
// - Apply drives scan clock, clear and data to load whole image.
// - Delay code 0100 is one ns; delay uses low four data bits.
// - One-bit parameters read back in bit zero.
// - Chain bit zero shifted last; highest bit shifted first.
// - n fields at bits 0-23, m repeats the layout at 24-47.
// - Post-scale blocks of 24 bits from 48 to 287, g, l, e order.
// - Short chain ends after local 1 delay, 193 bits with enable bit.
// - First bit shifted is the transfer enable, driven high.
// - Each field goes most significant bit first.
// - Write stores data into selected field, busy until stored.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "pscr_regs.svh"

module pscr_loader
    import pscr_pkg::*;
#(
    parameter bit LONG_CHAIN = 1'b1
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        chain_done_in,
    output pscr_scan_t       scan_out
);

    localparam int CHAIN_LEN = LONG_CHAIN ? `PSCR_CHAIN_LONG
                                          : `PSCR_CHAIN_SHORT;
    localparam int HALF = `PSCR_SCAN_HALF_CYC;
    localparam int CLRC = `PSCR_CLR_CYC;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ACCESS, ST_CLEAR, ST_LOW, ST_HIGH, ST_DONE
    } pscr_state_t;

    // Cache: bits 0..287 the counter fields; bit 288 is never written, the shifted transfer enable is driven high
    logic [288:0]     cache_reg;
    pscr_state_t      state_reg;
    pscr_op_t         op_reg;
    pscr_sel_t        sel_reg;
    logic [8:0]       wdata_reg;
    logic [8:0]       rdata_reg;
    logic             use_done_reg;
    logic             illegal_reg;
    logic [8:0]       bit_idx_reg;
    logic [7:0]       tmr_reg;
    logic             busy_reg;
    pscr_scan_t       scan_reg;
    logic             done_s1_reg;
    logic             done_s2_reg;
    logic             aw_hold_reg;
    logic             w_hold_reg;
    logic [11:0]      awaddr_reg;
    logic [31:0]      wbuf_reg;

    // Decoded field position and width from the selects
    logic [8:0]       fbase;
    logic [3:0]       fwidth;
    logic             sel_ok;

    // Field decode
    always_comb begin
        logic [8:0] blk;
        blk    = 9'h000;
        fbase  = 9'h000;
        fwidth = 4'h0;
        sel_ok = 1'b1;
        case (sel_reg.counter_sel[3:2])
            2'b00: begin
                blk = sel_reg.counter_sel[1] ? 9'h000 :
                      (sel_reg.counter_sel[0] ? 9'(`PSCR_FIELD_BASE_M)
                                              : 9'h000);
                sel_ok = ~sel_reg.counter_sel[1];
            end
            2'b01: blk = 9'(`PSCR_POST_BASE) + 9'(`PSCR_BLOCK_BITS)
                         * {7'h00, sel_reg.counter_sel[1:0]};
            2'b10: begin
                // Local blocks sit after the four core blocks
                blk = 9'(`PSCR_POST_BASE) + 9'(`PSCR_BLOCK_BITS)
                      * (9'h004 + {8'h00, sel_reg.counter_sel[0]});
                sel_ok = ~sel_reg.counter_sel[1];
            end
            default: begin
                // External blocks follow the six core and local blocks
                blk = 9'(`PSCR_POST_BASE) + 9'(`PSCR_BLOCK_BITS)
                      * (9'h006 + {7'h00, sel_reg.counter_sel[1:0]});
                sel_ok = LONG_CHAIN;
            end
        endcase
        case (sel_reg.param_sel)
            3'b000: begin
                fbase = blk;
                fwidth = 4'h9;
            end
            3'b001: begin
                fbase = blk + 9'(`PSCR_OFS_LOW);
                fwidth = 4'h9;
            end
            3'b010: begin
                fbase = blk + 9'(`PSCR_OFS_DELAY);
                fwidth = 4'h4;
            end
            3'b100: begin
                fbase = blk + 9'(`PSCR_OFS_BYPASS);
                fwidth = 4'h1;
            end
            3'b101: begin
                fbase = blk + 9'(`PSCR_OFS_ODD);
                fwidth = 4'h1;
            end
            default: begin
                fbase = blk;
                sel_ok = 1'b0;
            end
        endcase
    end

    // Chain-done synchroniser, the pin is on the PLL side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
        end else if (clk_en) begin
            done_s1_reg <= chain_done_in;
            done_s2_reg <= done_s1_reg;
        end
    end

    // AXI write side: address and data taken in either order
    logic wr_go;
    logic wr_idle;
    assign wr_idle = ~s_axi_bvalid;
    assign wr_go   = aw_hold_reg & w_hold_reg & wr_idle;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            awaddr_reg    <= 12'h000;
            wbuf_reg      <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else if (clk_en) begin
            s_axi_awready <= ~aw_hold_reg & ~s_axi_awready & wr_idle;
            s_axi_wready  <= ~w_hold_reg & ~s_axi_wready & wr_idle;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wbuf_reg   <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_reg == `PSCR_OFF_CTRL ||
                                 awaddr_reg == `PSCR_OFF_SEL ||
                                 awaddr_reg == `PSCR_OFF_WDATA ||
                                 awaddr_reg == `PSCR_OFF_CFG)
                                ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes to select, data and config, ignored while busy
    logic wr_low;
    assign wr_low = wr_go & s_axi_wstrb[0] & ~busy_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sel_reg      <= '0;
            wdata_reg    <= 9'h000;
            use_done_reg <= 1'b0;
        end else if (clk_en && wr_low) begin
            if (awaddr_reg == `PSCR_OFF_SEL)
                sel_reg <= pscr_sel_t'(wbuf_reg[6:0]);
            if (awaddr_reg == `PSCR_OFF_WDATA && s_axi_wstrb[1])
                wdata_reg <= wbuf_reg[8:0];
            if (awaddr_reg == `PSCR_OFF_CFG)
                use_done_reg <= wbuf_reg[`PSCR_CFG_USE_DONE];
        end
    end

    // Command decode: one write to the control register is one request
    pscr_op_t cmd;
    always_comb begin
        cmd = PSCR_OP_NONE;
        if (wr_low && awaddr_reg == `PSCR_OFF_CTRL) begin
            if (wbuf_reg[`PSCR_CTRL_APPLY])
                cmd = PSCR_OP_APPLY;
            else if (wbuf_reg[`PSCR_CTRL_WRITE])
                cmd = PSCR_OP_WRITE;
            else if (wbuf_reg[`PSCR_CTRL_READ])
                cmd = PSCR_OP_READ;
        end
    end

    // Main sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg   <= ST_IDLE;
            op_reg      <= PSCR_OP_NONE;
            busy_reg    <= 1'b0;
            bit_idx_reg <= 9'h000;
            tmr_reg     <= 8'h00;
            scan_reg    <= '0;
        end else if (clk_en) begin
            case (state_reg)
                ST_IDLE: begin
                    scan_reg <= '0;
                    if (cmd == PSCR_OP_APPLY) begin
                        busy_reg  <= 1'b1;
                        state_reg <= ST_CLEAR;
                        tmr_reg   <= 8'(CLRC);
                        scan_reg.scan_clr <= 1'b1;
                    end else if (cmd != PSCR_OP_NONE) begin
                        busy_reg  <= 1'b1;
                        op_reg    <= cmd;
                        state_reg <= ST_ACCESS;
                    end
                end
                ST_ACCESS: begin
                    busy_reg  <= 1'b0;
                    state_reg <= ST_IDLE;
                end
                ST_CLEAR: begin
                    if (tmr_reg <= 8'h01) begin
                        scan_reg.scan_clr <= 1'b0;
                        // Transfer enable leads, highest bit first
                        bit_idx_reg <= 9'(CHAIN_LEN - 1);
                        tmr_reg     <= 8'(HALF);
                        state_reg   <= ST_LOW;
                    end else begin
                        tmr_reg <= tmr_reg - 8'h01;
                    end
                end
                ST_LOW: begin
                    // Data changes while the scan clock is low
                    scan_reg.scan_data <= (bit_idx_reg == 9'(CHAIN_LEN - 1))
                        ? 1'b1 : cache_reg[bit_idx_reg];
                    if (tmr_reg <= 8'h01) begin
                        scan_reg.scan_clk <= 1'b1;
                        tmr_reg   <= 8'(HALF);
                        state_reg <= ST_HIGH;
                    end else begin
                        tmr_reg <= tmr_reg - 8'h01;
                    end
                end
                ST_HIGH: begin
                    if (tmr_reg <= 8'h01) begin
                        scan_reg.scan_clk <= 1'b0;
                        tmr_reg <= 8'(HALF);
                        if (bit_idx_reg == 9'h000) begin
                            state_reg <= ST_DONE;
                            tmr_reg   <= 8'(`PSCR_DONE_WAIT);
                        end else begin
                            bit_idx_reg <= bit_idx_reg - 9'h001;
                            state_reg   <= ST_LOW;
                        end
                    end else begin
                        tmr_reg <= tmr_reg - 8'h01;
                    end
                end
                ST_DONE: begin
                    scan_reg <= '0;
                    // Without the done input, wait a fixed settle time
                    if (use_done_reg ? done_s2_reg
                                     : (tmr_reg <= 8'h01)) begin
                        busy_reg  <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else if (tmr_reg > 8'h01) begin
                        tmr_reg <= tmr_reg - 8'h01;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy_reg  <= 1'b0;
                end
            endcase
        end
    end

    assign scan_out = scan_reg;

    // Cache update: only the selected field changes, apply never writes
    genvar gi;
    generate
        for (gi = 0; gi < 289; gi++) begin : g_cache
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    cache_reg[gi] <= 1'b0;
                end else if (clk_en && state_reg == ST_ACCESS &&
                             op_reg == PSCR_OP_WRITE && sel_ok &&
                             gi >= fbase && gi < fbase + fwidth) begin
                    cache_reg[gi] <= wdata_reg[gi - fbase];
                end
            end
        end
    endgenerate

    // Read fetch, right-aligned; flags illegal selects
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_reg   <= 9'h000;
            illegal_reg <= 1'b0;
        end else if (clk_en && state_reg == ST_ACCESS) begin
            illegal_reg <= ~sel_ok;
            if (op_reg == PSCR_OP_READ) begin
                for (int k = 0; k < 9; k++) begin
                    rdata_reg[k] <= (k < fwidth && sel_ok)
                        ? cache_reg[9'(fbase + 9'(k))] : 1'b0;
                end
            end
        end
    end

    // AXI read side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else if (clk_en) begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'h0;
                case (s_axi_araddr)
                    `PSCR_OFF_SEL:    s_axi_rdata <= {25'h0, sel_reg};
                    `PSCR_OFF_WDATA:  s_axi_rdata <= {23'h0, wdata_reg};
                    `PSCR_OFF_RDATA:  s_axi_rdata <= {23'h0, rdata_reg};
                    `PSCR_OFF_STATUS: s_axi_rdata <= {29'h0, done_s2_reg,
                                                      illegal_reg, busy_reg};
                    `PSCR_OFF_CFG:    s_axi_rdata <= {31'h0, use_done_reg};
                    `PSCR_OFF_CTRL:   s_axi_rdata <= 32'h0000_0000;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'h2;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : pscr_loader

// *** logic/pscr_pkg.sv ***
// Types shared by the scan chain loader
package pscr_pkg;

    typedef enum logic [1:0] {
        PSCR_OP_NONE,
        PSCR_OP_READ,
        PSCR_OP_WRITE,
        PSCR_OP_APPLY
    } pscr_op_t;

    typedef struct packed {
        logic [3:0] counter_sel;
        logic [2:0] param_sel;
    } pscr_sel_t;

    typedef struct packed {
        logic scan_clk;
        logic scan_clr;
        logic scan_data;
    } pscr_scan_t;

endpackage : pscr_pkg

// *** logic/pscr_regs.svh ***
// Register-bus offsets, field positions and timing counts for the loader
`ifndef PSCR_REGS_SVH
`define PSCR_REGS_SVH

// AXI4-Lite byte offsets
`define PSCR_OFF_CTRL      12'h000
`define PSCR_OFF_SEL       12'h004
`define PSCR_OFF_WDATA     12'h008
`define PSCR_OFF_RDATA     12'h00C
`define PSCR_OFF_STATUS    12'h010
`define PSCR_OFF_CFG       12'h014

// Control register command bits (write one to start)
`define PSCR_CTRL_READ     0
`define PSCR_CTRL_WRITE    1
`define PSCR_CTRL_APPLY    2

// Status bits
`define PSCR_STAT_BUSY     0
`define PSCR_STAT_ILLEGAL  1
`define PSCR_STAT_DONE_IN  2

// Config bits
`define PSCR_CFG_USE_DONE  0

// Chain geometry
`define PSCR_CHAIN_LONG    289
`define PSCR_CHAIN_SHORT   193
`define PSCR_FIELD_BASE_M  24
`define PSCR_POST_BASE     48
`define PSCR_BLOCK_BITS    24
`define PSCR_OFS_BYPASS    9
`define PSCR_OFS_LOW       10
`define PSCR_OFS_ODD       19
`define PSCR_OFS_DELAY     20

// Scan clock timing: half period and clear pulse, in ns and cycles
`define PSCR_CLK_NS        8
`define PSCR_SCAN_HALF_NS  32
`define PSCR_SCAN_HALF_CYC ((`PSCR_SCAN_HALF_NS + `PSCR_CLK_NS - 1) / `PSCR_CLK_NS)
`define PSCR_CLR_NS        5
`define PSCR_CLR_CYC       ((`PSCR_CLR_NS + `PSCR_CLK_NS - 1) / `PSCR_CLK_NS)
`define PSCR_DONE_WAIT     16

`endif

// *** tb/pscr_loader_monitor.sv ***
// Port checker for the scan chain loader
`timescale 1ns/10ps
module pscr_loader_monitor
    import pscr_pkg::*;
#(
    parameter bit LONG_CHAIN = 1'b1
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire pscr_scan_t  scan_out
);
    localparam int CHAIN_N = LONG_CHAIN ? 289 : 193;
    logic [8:0] edge_cnt;
    logic [3:0] idle_cnt;
    logic       clk_q;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Previous scan clock level
    always_ff @(posedge aclk) begin
        clk_q <= scan_out.scan_clk;
    end
    // Scan clock rises since the last clear
    always_ff @(posedge aclk) begin
        if (!aresetn || scan_out.scan_clr) begin
            edge_cnt <= '0;
        end else if (scan_out.scan_clk && !clk_q) begin
            edge_cnt <= edge_cnt + 9'h001;
        end
    end
    // Cleared while the scan clock is high, saturates at 15; a 4-cycle gap between bits stays below the frame-end count of 12
    always_ff @(posedge aclk) begin
        if (!aresetn || scan_out.scan_clk) begin
            idle_cnt <= '0;
        end else if (idle_cnt != 4'hF) begin
            idle_cnt <= idle_cnt + 4'h1;
        end
    end
    chk_reset_quiet: assert property ($rose(aresetn) |->
        scan_out == '0 && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not quiet after reset");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_clk_high: assert property ($rose(scan_out.scan_clk) |->
        scan_out.scan_clk [*4] ##1 !scan_out.scan_clk)
        else $error("scan clock high phase wrong");
    chk_clk_low: assert property ($fell(scan_out.scan_clk) |->
        !scan_out.scan_clk [*4])
        else $error("scan clock low phase too short");
    chk_data_steady: assert property (scan_out.scan_clk |->
        $stable(scan_out.scan_data))
        else $error("scan data moved while clock high");
    chk_clr_pulse: assert property ($rose(scan_out.scan_clr) |=>
        !scan_out.scan_clr && !scan_out.scan_clk)
        else $error("clear pulse wrong");
    chk_enable_first: assert property ($rose(scan_out.scan_clk) &&
        edge_cnt == 9'h000 |-> scan_out.scan_data)
        else $error("first chain bit not high");
    chk_bit_total: assert property (idle_cnt == 4'hC |->
        edge_cnt == 9'h000 || edge_cnt == CHAIN_N)
        else $error("frame bit count wrong");
    cover property ($fell(scan_out.scan_clk) && edge_cnt == CHAIN_N);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    cover property ($rose(scan_out.scan_clr));
endmodule : pscr_loader_monitor

bind pscr_loader pscr_loader_monitor #(.LONG_CHAIN(LONG_CHAIN))
    i_pscr_loader_monitor (.aclk(aclk), .aresetn(aresetn),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .scan_out(scan_out));

// *** tb/pscr_loader_test.sv ***
// Self-checking bench for the scan chain loader
`timescale 1ns/10ps
`include "pscr_regs.svh"
module pscr_loader_test import pscr_pkg::*;;
    logic         aclk, aresetn, clk_en, awvalid, awready, wvalid, wready;
    logic         bvalid, bready, arvalid, arready, rvalid, rready;
    logic         chain_done;
    logic [11:0]  awaddr, araddr;
    logic [31:0]  wdata, rdata, st, rd, seed;
    logic [3:0]   wstrb;
    logic [1:0]   bresp, rresp, resp;
    logic [7:0]   done_lag;
    logic [6:0]   sel_m;
    logic [288:0] image;
    logic [287:0] cache_m;
    pscr_scan_t   scan;
    int unsigned  n_edges;
    int           n_fail, samples_checked, cycles;

    pscr_loader i_pscr_loader (.aclk(aclk), .aresetn(aresetn),
        .clk_en(clk_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .chain_done_in(chain_done), .scan_out(scan));
    pscr_pll_model i_pscr_pll_model (.aclk(aclk), .scan(scan),
        .done_lag(done_lag), .chain_done(chain_done), .image(image),
        .n_edges(n_edges));

    // 125 MHz clock
    always #4 aclk = ~aclk;

    task automatic check(input logic [288:0] seen, input logic [288:0] exp,
                         input string what);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s seen %0h expected %0h",
                     $time, what, seen, exp);
        end
    endtask : check

    task automatic end_of_test;
        $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // Address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_ok, w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge aclk);
            if (awvalid && awready) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (!bvalid) @(posedge aclk);
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge aclk);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic wait_idle;
        do axi_rd(`PSCR_OFF_STATUS, st); while (st[0] !== 1'b0);
    endtask : wait_idle

    // Chain bit of a field's LSB, or -1 for an illegal select
    function automatic int fpos(input logic [6:0] s);
        int c, p, b;
        c = int'(s[6:3]);
        p = int'(s[2:0]);
        b = c < 2 ? 24 * c : (c >= 4 && c <= 9) ? 48 + 24 * (c - 4) :
            c >= 12 ? 48 + 24 * (c - 6) : -1;
        if (b < 0 || p == 3 || p > 5) return -1;
        return b + (p == 0 ? 0 : p == 1 ? 10 : p == 2 ? 20 : p == 4 ? 9 : 19);
    endfunction : fpos

    // One field command, mirrored on the bench's own cache copy
    task automatic field_op(input logic [6:0] s, input logic wr);
        int          b;
        logic [31:0] v, e;
        b = fpos(s);
        v = $random(seed);
        e = '0;
        if (s[6:4] == 3'h0 && s[2:0] == 3'h5) v = '0;
        axi_wr(`PSCR_OFF_SEL, {25'h0, s});
        sel_m = s;
        if (wr) axi_wr(`PSCR_OFF_WDATA, v);
        axi_wr(`PSCR_OFF_CTRL, wr ? 32'h2 : 32'h1);
        wait_idle;
        check(st[1], b < 0, "illegal flag");
        for (int k = 0; k < (s[2:0] < 2 ? 9 : s[2:0] == 2 ? 4 : 1); k++) begin
            if (b >= 0 && wr) cache_m[b + k] = v[k];
            if (b >= 0) e[k] = cache_m[b + k];
        end
        if (!wr) begin
            axi_rd(`PSCR_OFF_RDATA, rd);
            check(rd, e, "field read");
        end
    endtask : field_op

    task automatic all_fields(input logic wr);
        for (int i = 0; i < 128; i++) field_op(i[6:0], wr);
    endtask : all_fields

    // Load the chain; commands sent meanwhile must be dropped
    task automatic apply(input logic use_done, input logic [7:0] lag);
        axi_wr(`PSCR_OFF_CFG, {31'h0, use_done});
        done_lag <= lag;
        axi_wr(`PSCR_OFF_CTRL, 32'h4);
        axi_rd(`PSCR_OFF_STATUS, st);
        check(st[0], 1'b1, "busy on apply");
        axi_wr(`PSCR_OFF_SEL, {25'h0, ~sel_m});
        axi_wr(`PSCR_OFF_CTRL, 32'h2);
        axi_rd(`PSCR_OFF_SEL, rd);
        check(rd, {25'h0, sel_m}, "select while busy");
        while (n_edges != 289) @(posedge aclk);
        repeat (40) @(posedge aclk);
        axi_rd(`PSCR_OFF_STATUS, st);
        check(st[0], use_done, "busy vs chain done");
        wait_idle;
        check(chain_done, use_done, "done at idle");
        check(image, {1'b1, cache_m}, "chain image");
        check(n_edges, 289, "scan clock rises");
    endtask : apply

    // Hang guard
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            end_of_test;
        end
    end

    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, n_fail, samples_checked, cycles} = '0;
        clk_en = 1'b1;
        wstrb = 4'hF;
        seed = 32'hBD92;
        done_lag = 8'hC8;
        cache_m = '0;
        sel_m = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(`PSCR_OFF_STATUS, st);
        check(st, 32'h0, "status after reset");
        axi_rd(12'h0FC, rd);
        check(resp, 2'h2, "unmapped read");
        all_fields(1'b1);
        all_fields(1'b0);
        apply(1'b0, 8'hC8);
        field_op(7'h32, 1'b1);
        apply(1'b1, 8'h78);
        all_fields(1'b0);
        end_of_test;
    end
endmodule : pscr_loader_test

// *** tb/pscr_pll_model.sv ***
// Behavioural scan chain of the PLL being loaded
`timescale 1ns/10ps
module pscr_pll_model
    import pscr_pkg::*;
#(
    parameter bit LONG_CHAIN = 1'b1
) (
    input wire logic        aclk,
    input wire pscr_scan_t  scan,
    input wire logic [7:0]  done_lag,
    output logic            chain_done,
    output logic [288:0]    image,
    output int unsigned     n_edges
);
    localparam int CHAIN_N = LONG_CHAIN ? 289 : 193;
    logic        clk_q = 1'b0;
    int unsigned lag_cnt = 0;
    initial begin
        chain_done = 1'b0;
        image = '0;
        n_edges = 0;
    end
    // Scan clock sampled by the fast clock; clear wipes the whole chain
    always @(posedge aclk) begin
        clk_q <= scan.scan_clk;
        if (scan.scan_clr) begin
            image <= '0;
            n_edges <= 0;
            lag_cnt <= 0;
            chain_done <= 1'b0;
        end else begin
            if (scan.scan_clk && !clk_q) begin
                image <= {image[287:0], scan.scan_data};
                n_edges <= n_edges + 1;
            end
            // Done may lag so the loader cannot rely on a prompt answer
            if (n_edges == CHAIN_N && lag_cnt == done_lag) begin
                chain_done <= 1'b1;
            end else if (n_edges == CHAIN_N) begin
                lag_cnt <= lag_cnt + 1;
            end
        end
    end
endmodule : pscr_pll_model
